/* File: src/psc_pkg.sv */
// Purpose: Constants for the positioning sequence control device logic
// Assumes: 20 MHz core clock, synchronous active-low reset
// Notes: Active-low lines are named with _n, except the reset, resetn_in
package psc_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int POS_W = 3;
    localparam int DIST_W = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int SERVO_SETTLE_US = 1000;
    localparam int SERVO_SETTLE_CYC = (SERVO_SETTLE_US * (CLK_HZ / 1_000_000));
    localparam logic [DIST_W-1:0] STEP_PER_POS = 16'h0040;
    localparam logic [POS_W-1:0] POS_RESET = 3'h0;

    // ------------------------------------------------------------
    // Motion states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PSC_OFF,
        PSC_SETTLE,
        PSC_IDLE,
        PSC_MOVE,
        PSC_HOLD
    } psc_state_t;

endpackage : psc_pkg

/* File: src/psc_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to core_clk_in
// Notes: First stage read only by the second
`timescale 1ns/1ns
`default_nettype none
module psc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock, reset and clock enable
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_r;
    logic [W-1:0] s2_nxt;

    always_comb begin
        s1_nxt = s1_r;
        s2_nxt = s2_r;
        if (ce_in) begin
            s1_nxt = d_in;
            s2_nxt = s1_r;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            s1_r <= INIT;
            s2_r <= INIT;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q_out = s2_r;
endmodule : psc_sync
`default_nettype wire

/* File: src/psc_top.sv */
// Purpose: Device-side sequencing for a point-positioning actuator
// Assumes: Parallel handshake pins from an external controller
// Notes: Travel is modelled by a distance counter, one step per cycle
`timescale 1ns/1ns
`default_nettype none
module psc_top #(
    parameter int SETTLE_CYC = psc_pkg::SERVO_SETTLE_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // Safety and mode pins
    input wire logic emg_stop_n_in,
    input wire logic auto_mode_in,
    input wire logic pendant_present_in,
    input wire logic dummy_plug_present_in,
    // Command pins from controller
    input wire logic servo_enable_request_in,
    input wire logic move_start_strobe_in,
    input wire logic pause_request_n_in,
    input wire logic clear_request_in,
    input wire logic target_position_bit0_in,
    input wire logic target_position_bit1_in,
    input wire logic target_position_bit2_in,
    // Status pins to controller
    output logic ready_complete_flag_out,
    output logic positioning_done_out,
    output logic homing_done_out,
    output logic alarm_n_out,
    output logic moving_out,
    output logic done_position_bit0_out,
    output logic done_position_bit1_out,
    output logic done_position_bit2_out,
    output logic operating_mode_status_out,
    output logic emergency_stop_out
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NIN = 12;
    logic [NIN-1:0] raw_w;
    logic [NIN-1:0] syn_w;

    assign raw_w = {emg_stop_n_in, auto_mode_in, pendant_present_in, dummy_plug_present_in,
                    servo_enable_request_in, move_start_strobe_in, pause_request_n_in,
                    clear_request_in, target_position_bit2_in, target_position_bit1_in,
                    target_position_bit0_in, 1'b0};

    psc_sync #(
        .W(NIN),
        .INIT(12'h820)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .ce_in(clk_en_in),
        .d_in(raw_w),
        .q_out(syn_w)
    );

    logic emg_n_s;
    logic auto_s;
    logic positioning_done_s;
    logic plug_s;
    logic son_s;
    logic move_start_strobe_s;
    logic hold_s;
    logic clr_s;
    logic [psc_pkg::POS_W-1:0] tgt_s;

    assign emg_n_s = syn_w[11];
    assign auto_s = syn_w[10];
    assign positioning_done_s = syn_w[9];
    assign plug_s = syn_w[8];
    assign son_s = syn_w[7];
    assign move_start_strobe_s = syn_w[6];
    assign hold_s = !syn_w[5];
    assign clr_s = syn_w[4];
    assign tgt_s = syn_w[3:1];

    // ------------------------------------------------------------
    // Emergency stop
    // ------------------------------------------------------------
    logic estop_w;
    assign estop_w = !emg_n_s || (auto_s && !positioning_done_s && !plug_s);

    // ------------------------------------------------------------
    // Motion state
    // ------------------------------------------------------------
    psc_pkg::psc_state_t state_r;
    psc_pkg::psc_state_t state_nxt;
    logic [31:0] settle_r;
    logic [31:0] settle_nxt;
    logic [psc_pkg::DIST_W-1:0] remain_r;
    logic [psc_pkg::DIST_W-1:0] remain_nxt;
    logic [psc_pkg::POS_W-1:0] cur_pos_r;
    logic [psc_pkg::POS_W-1:0] cur_pos_nxt;
    logic [psc_pkg::POS_W-1:0] goal_r;
    logic [psc_pkg::POS_W-1:0] goal_nxt;
    logic [psc_pkg::POS_W-1:0] done_pos_r;
    logic [psc_pkg::POS_W-1:0] done_pos_nxt;
    logic done_r;
    logic done_nxt;
    logic homed_r;
    logic homed_nxt;
    logic move_start_strobe_d_r;
    logic move_start_strobe_d_nxt;
    logic start_w;

    function automatic logic [psc_pkg::DIST_W-1:0] dist_of(
        input logic [psc_pkg::POS_W-1:0] a,
        input logic [psc_pkg::POS_W-1:0] b
    );
        logic [psc_pkg::POS_W-1:0] d;
        d = (a > b) ? a - b : b - a;
        dist_of = psc_pkg::DIST_W'(d) * psc_pkg::STEP_PER_POS;
    endfunction : dist_of

    assign start_w = move_start_strobe_s && !move_start_strobe_d_r;

    always_comb begin
        state_nxt = state_r;
        settle_nxt = settle_r;
        remain_nxt = remain_r;
        cur_pos_nxt = cur_pos_r;
        goal_nxt = goal_r;
        done_pos_nxt = done_pos_r;
        done_nxt = done_r;
        homed_nxt = homed_r;
        move_start_strobe_d_nxt = move_start_strobe_s;
        if (estop_w || !son_s) begin
            state_nxt = psc_pkg::PSC_OFF;
            remain_nxt = '0;
            settle_nxt = '0;
        end else begin
            unique case (state_r)
                psc_pkg::PSC_OFF: begin
                    state_nxt = psc_pkg::PSC_SETTLE;
                    settle_nxt = '0;
                end
                psc_pkg::PSC_SETTLE: begin
                    if (settle_r >= 32'(SETTLE_CYC - 1)) begin
                        state_nxt = psc_pkg::PSC_IDLE;
                        homed_nxt = 1'b1;
                    end else begin
                        settle_nxt = settle_r + 32'h1;
                    end
                end
                psc_pkg::PSC_IDLE: begin
                    if (start_w && !hold_s) begin
                        goal_nxt = tgt_s;
                        remain_nxt = dist_of(cur_pos_r, tgt_s);
                        done_nxt = 1'b0;
                        state_nxt = psc_pkg::PSC_MOVE;
                    end
                end
                psc_pkg::PSC_MOVE: begin
                    if (hold_s) begin
                        state_nxt = psc_pkg::PSC_HOLD;
                    end else if (remain_r == '0) begin
                        cur_pos_nxt = goal_r;
                        done_pos_nxt = goal_r;
                        done_nxt = 1'b1;
                        state_nxt = psc_pkg::PSC_IDLE;
                    end else begin
                        remain_nxt = remain_r - 16'h1;
                    end
                end
                psc_pkg::PSC_HOLD: begin
                    if (clr_s) begin
                        remain_nxt = '0;
                        state_nxt = psc_pkg::PSC_IDLE;
                    end else if (!hold_s) begin
                        state_nxt = psc_pkg::PSC_MOVE;
                    end
                end
                default: state_nxt = psc_pkg::PSC_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_r <= psc_pkg::PSC_OFF;
            settle_r <= '0;
            remain_r <= '0;
            cur_pos_r <= psc_pkg::POS_RESET;
            goal_r <= psc_pkg::POS_RESET;
            done_pos_r <= psc_pkg::POS_RESET;
            done_r <= 1'b0;
            homed_r <= 1'b0;
            move_start_strobe_d_r <= 1'b0;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
            settle_r <= settle_nxt;
            remain_r <= remain_nxt;
            cur_pos_r <= cur_pos_nxt;
            goal_r <= goal_nxt;
            done_pos_r <= done_pos_nxt;
            done_r <= done_nxt;
            homed_r <= homed_nxt;
            move_start_strobe_d_r <= move_start_strobe_d_nxt;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    logic rdy_r;
    logic rdy_nxt;
    logic alm_n_r;
    logic alm_n_nxt;
    logic estop_r;
    logic auto_r;

    always_comb begin
        rdy_nxt = (state_nxt != psc_pkg::PSC_OFF) && (state_nxt != psc_pkg::PSC_SETTLE);
        alm_n_nxt = 1'b1;
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rdy_r <= 1'b0;
            alm_n_r <= 1'b1;
            estop_r <= 1'b0;
            auto_r <= 1'b0;
        end else if (clk_en_in) begin
            rdy_r <= rdy_nxt;
            alm_n_r <= alm_n_nxt;
            estop_r <= estop_w;
            auto_r <= auto_s;
        end
    end

    assign ready_complete_flag_out = rdy_r;
    assign positioning_done_out = done_r;
    assign homing_done_out = homed_r;
    assign alarm_n_out = alm_n_r;
    assign moving_out = (state_r == psc_pkg::PSC_MOVE);
    assign done_position_bit0_out = done_pos_r[0];
    assign done_position_bit1_out = done_pos_r[1];
    assign done_position_bit2_out = done_pos_r[2];
    assign operating_mode_status_out = auto_r;
    assign emergency_stop_out = estop_r;
endmodule : psc_top
`default_nettype wire

/* File: sim/psc_top_props.sv */
// Purpose: Port assertions for psc_top
// Assumes: clk_en_in held high
// Notes: Bounds allow two sync flops plus output registers
`timescale 1ns/1ns
`default_nettype none
module psc_top_props (
    // Inputs
    input wire logic core_clk_in, resetn_in, emg_stop_n_in, auto_mode_in,
    input wire logic pendant_present_in, dummy_plug_present_in, servo_enable_request_in,
    input wire logic move_start_strobe_in, pause_request_n_in, clear_request_in,
    input wire logic target_position_bit0_in, target_position_bit1_in, target_position_bit2_in,
    // Outputs
    input wire logic ready_complete_flag_out, positioning_done_out, alarm_n_out, moving_out,
    input wire logic done_position_bit0_out, done_position_bit1_out, done_position_bit2_out,
    input wire logic emergency_stop_out
);
    // ------------------------------
    // Properties
    // ------------------------------
    logic no_plug;
    assign no_plug = auto_mode_in && !pendant_present_in && !dummy_plug_present_in;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_start;
        $rose(moving_out);
    endsequence
    sequence s_cleared;
        (!pause_request_n_in && clear_request_in && !positioning_done_out)[*6] ##1
            (pause_request_n_in && !$rose(move_start_strobe_in))[*8];
    endsequence
    property p_no_plug;
        (no_plug && emg_stop_n_in)[*4] |-> ##[0:4] emergency_stop_out;
    endproperty
    a_no_plug: assert property (p_no_plug) else $error("no estop");
    property p_emg_low;
        !emg_stop_n_in[*4] |-> ##[0:4] (emergency_stop_out && !moving_out);
    endproperty
    a_emg_low: assert property (p_emg_low) else $error("estop late");
    property p_alarm;
        alarm_n_out;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm low");
    property p_ready_drop;
        !servo_enable_request_in[*3] |-> ##[0:4] !ready_complete_flag_out;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready stuck");
    property p_pause_n;
        !pause_request_n_in[*4] |-> ##[0:4] !moving_out;
    endproperty
    a_pause_n: assert property (p_pause_n) else $error("no hold");
    property p_clear;
        s_cleared |-> !moving_out && !positioning_done_out;
    endproperty
    a_clear: assert property (p_clear) else $error("travel resumed");
    property p_done_pos;
        $rose(positioning_done_out) |-> !moving_out && {done_position_bit2_out,
            done_position_bit1_out, done_position_bit0_out} == {target_position_bit2_in,
            target_position_bit1_in, target_position_bit0_in};
    endproperty
    a_done_pos: assert property (p_done_pos) else $error("bad position");
    property p_start;
        s_start |-> !positioning_done_out;
    endproperty
    a_start: assert property (p_start) else $error("done kept");
endmodule : psc_top_props
bind psc_top psc_top_props u_props (.core_clk_in, .resetn_in, .emg_stop_n_in, .auto_mode_in,
    .pendant_present_in, .dummy_plug_present_in, .servo_enable_request_in,
    .move_start_strobe_in, .pause_request_n_in, .clear_request_in, .target_position_bit0_in,
    .target_position_bit1_in, .target_position_bit2_in, .ready_complete_flag_out,
    .positioning_done_out, .alarm_n_out, .moving_out, .done_position_bit0_out,
    .done_position_bit1_out, .done_position_bit2_out, .emergency_stop_out);
`default_nettype wire

/* File: sim/psc_plc_model.sv */
// Purpose: Controller model driving psc_top command pins
// Assumes: Operator buttons are short pulses
// Notes: WAIT_CYC shortens the start wait
`timescale 1ns/1ns
`default_nettype none
module psc_plc_model #(
    parameter int WAIT_CYC = 20
) (
    // Clock, reset, buttons
    input wire logic core_clk_in, resetn_in, release_in, run_in, stop_in, pause_btn_in,
    // Device status
    input wire logic ready_in, done_in,
    input wire logic [2:0] done_pos_in,
    // Commands and lamps
    output logic servo_out, strobe_out, pause_n_out, clear_out, pause_lamp_out, release_lamp_out,
    output logic [2:0] target_out,
    output logic [3:1] onehot_out
);
    // ------------------------------
    // Ladder sequence
    // ------------------------------
    logic pb_q, running, paused;
    logic [1:0] st;
    logic [7:0] cnt, ccnt;
    assign onehot_out = {done_pos_in == 3'h3, done_pos_in == 3'h2, done_pos_in == 3'h1};
    assign release_lamp_out = ready_in;
    assign pause_lamp_out = paused;
    assign pause_n_out = !paused;
    always_ff @(posedge core_clk_in) begin
        pb_q <= pause_btn_in;
        servo_out <= resetn_in && release_in;
        if (!resetn_in) begin
            {running, paused, clear_out, strobe_out, st, cnt, ccnt, target_out} <= '0;
        end else begin
            if (pause_btn_in && !pb_q) paused <= !paused;
            if (stop_in && !paused) running <= 1'b0;
            if (stop_in && paused) clear_out <= 1'b1;
            if (clear_out) ccnt <= ccnt + 8'h01;
            if (ccnt == 8'h08) {clear_out, paused, running, strobe_out, st, ccnt} <= '0;
            case (st)
                2'h1: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(WAIT_CYC)) {strobe_out, st} <= 3'h6;
                end
                2'h2: if (!done_in) st <= 2'h3;
                2'h3: if (done_in) begin
                    {strobe_out, cnt} <= '0;
                    target_out <= (target_out == 3'h3) ? 3'h1 : target_out + 3'h1;
                    st <= running ? 2'h1 : 2'h0;
                end
                default: ;
            endcase
            if (run_in) {running, st, cnt, target_out} <= {1'b1, 2'h1, 8'h00, 3'h1};
        end
    end
endmodule : psc_plc_model
`default_nettype wire

/* File: sim/test_positioning_sequence_control.sv */
// Purpose: Self-checking bench for psc_top
// Assumes: Settle shortened, start wait kept at its default of 20
// Notes: Fixed seed
`timescale 1ns/1ns
`default_nettype none
module test_positioning_sequence_control;
    logic clk, rstn, emg_n, auto_m, positioning_done, plug, rel, run, stop, pbtn;
    logic servo, stb, pause_n, clr, ready, done, moving, alarm_n, estop, mode, rl, pl, homed;
    logic [2:0] tgt, dpos;
    logic [3:1] hot;
    int n_errors = 0;
    int total_checks = 0;
    int d;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    psc_top #(.SETTLE_CYC(4)) u_dut (.core_clk_in(clk), .resetn_in(rstn), .clk_en_in(1'b1),
        .emg_stop_n_in(emg_n), .auto_mode_in(auto_m), .pendant_present_in(positioning_done),
        .dummy_plug_present_in(plug), .servo_enable_request_in(servo),
        .move_start_strobe_in(stb), .pause_request_n_in(pause_n), .clear_request_in(clr),
        .target_position_bit0_in(tgt[0]), .target_position_bit1_in(tgt[1]),
        .target_position_bit2_in(tgt[2]), .ready_complete_flag_out(ready),
        .positioning_done_out(done), .homing_done_out(homed), .alarm_n_out(alarm_n),
        .moving_out(moving), .done_position_bit0_out(dpos[0]), .done_position_bit1_out(dpos[1]),
        .done_position_bit2_out(dpos[2]), .operating_mode_status_out(mode),
        .emergency_stop_out(estop));
    psc_plc_model #(.WAIT_CYC(20)) u_plc (.core_clk_in(clk), .resetn_in(rstn),
        .release_in(rel), .run_in(run), .stop_in(stop), .pause_btn_in(pbtn), .ready_in(ready),
        .done_in(done), .done_pos_in(dpos), .servo_out(servo), .strobe_out(stb),
        .pause_n_out(pause_n), .clear_out(clr), .pause_lamp_out(pl), .release_lamp_out(rl),
        .target_out(tgt), .onehot_out(hot));
    function automatic logic [3:0] exp_pos(input int k);
        return 4'(k % 3 + 1);
    endfunction : exp_pos
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic push(input int b);
        @(posedge clk) {run, stop, pbtn} <= 3'(b);
        @(posedge clk) {run, stop, pbtn} <= 3'h0;
    endtask : push
    task automatic wait_done();
        int i;
        i = 0;
        while (i < 900 && done !== 1'b0) begin
            cyc(1);
            i++;
        end
        while (i < 900 && done !== 1'b1) begin
            cyc(1);
            i++;
        end
        chk({3'h0, i < 900}, 4'h1);
    endtask : wait_done
    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        {rstn, emg_n, auto_m, positioning_done, plug, rel, run, stop, pbtn} = 9'h080;
        d = $urandom(32'h2260);
        cyc(20);
        rstn <= 1'b1;
        positioning_done <= 1'($urandom_range(1, 0));
        cyc(2);
        chk({alarm_n, ready, done, moving}, 4'h8);
        chk({homed, dpos}, 4'h0);
        rel <= 1'b1;
        cyc(24);
        chk({servo, ready, rl, estop}, 4'he);
        chk({3'h0, homed}, 4'h1);
        push(4);
        for (int k = 0; k < 4; k++) begin
            if (k == 1) begin
                cyc($urandom_range(70, 35));
                push(1);
                cyc(8);
                chk({2'h0, moving, pl}, 4'h1);
                push(1);
            end
            wait_done();
            chk({1'b0, dpos}, exp_pos(k));
            chk({hot, 1'b0}, 4'h1 << exp_pos(k));
        end
        cyc(40);
        push(1);
        cyc(8);
        push(2);
        cyc(60);
        chk({moving, done, pl, clr}, 4'h0);
        {auto_m, positioning_done, plug} <= 3'h4;
        cyc(8);
        chk({estop, ready, mode, 1'b0}, 4'ha);
        plug <= 1'b1;
        cyc(24);
        chk({estop, ready, 2'h0}, 4'h4);
        push(4);
        cyc(70);
        chk({3'h0, moving}, 4'h1);
        emg_n <= 1'b0;
        cyc(8);
        chk({estop, ready, moving, 1'b0}, 4'h8);
        emg_n <= 1'b1;
        cyc(24);
        chk({ready, estop, homed, moving}, 4'ha);
        rel <= 1'b0;
        cyc(8);
        chk({servo, ready, rl, moving}, 4'h0);
        wrap_up();
    end
    initial begin
        cyc(20000);
        n_errors++;
        wrap_up();
    end
endmodule : test_positioning_sequence_control
`default_nettype wire
